// >>> src/srtc_refresh_timing.sv
// refresh control, self-refresh sequencing and command spacing guard of the ddr2 controller
//
// Overview of operation
// - bit 31 set enters self-refresh; cleared, leaves self-refresh.
// - refresh bits 29-16 and timing bit 2 read zero, writes ignored.
// - bits 15-0 give auto-refresh period in system-clock cycles.
// - written rate below 0x0100 loads twice the refresh-cycle field instead.
// - refresh-cycle gap plus one from refresh/load-mode to refresh/activate.
// - precharge gap plus one from precharge to refresh or activate.
// - activate-to-access gap plus one from activate to read or write.
// - write-recovery gap plus one from last write data to precharge.
// - changing write-recovery field with controller enabled starts initialization.
// - activate-to-precharge gap plus one from activate to precharge, same bank.
// - activate cycle gap plus one between two successive activates.
// - bank-activate gap plus one between activates to different banks.
// - timing register writes take effect only while timing unlock is set.
// - write-to-read gap plus one from last write to a read.
`timescale 1ns/100ps
module srtc_refresh_timing (
  input  wire logic                        sys_clk_in,            // 10 MHz system clock
  input  wire logic                        rst_in,                // synchronous reset
  input  wire logic [srtc_pkg::ADDR_W-1:0] reg_addr_in,           // register byte address
  input  wire logic [31:0]                 reg_wdata_in,          // register write data
  input  wire logic                        reg_wr_in,             // write strobe
  input  wire logic                        reg_rd_in,             // read strobe
  output logic      [31:0]                 reg_rdata_out,         // read data, cycle after strobe
  input  wire logic                        act_issue_in,          // activate issued
  input  wire logic [srtc_pkg::BANK_W-1:0] act_bank_in,           // bank of the activate
  input  wire logic                        pre_issue_in,          // precharge issued
  input  wire logic                        ref_issue_in,          // auto-refresh issued
  input  wire logic                        lmr_issue_in,          // load-mode issued
  input  wire logic                        wr_last_in,            // last write data transfer
  input  wire logic                        sr_entered_in,         // memory now in self-refresh
  input  wire logic                        sr_exited_in,          // memory out of self-refresh
  output logic      [srtc_pkg::BANKS-1:0]  allow_act_out,         // activate allowed per bank
  output logic      [srtc_pkg::BANKS-1:0]  allow_pre_out,         // precharge allowed per bank
  output logic                             allow_rd_out,          // read allowed
  output logic                             allow_wr_out,          // write allowed
  output logic                             allow_ref_out,         // refresh allowed
  output logic                             refresh_req_out,       // auto-refresh due
  output logic                             self_refresh_req_out,  // drive memory to self-refresh
  output logic                             in_self_refresh_out,   // controller in self-refresh
  output logic                             init_start_out         // start initialization, pulse
);
  import srtc_pkg::*;

  // ----------------------------------------------------------------
  // field helpers
  // ----------------------------------------------------------------
  function automatic logic [GAP_W-1:0] gap_of(input logic [31:0] w, input int lsb,
                                              input int width);
    logic [31:0] f;
    f = (w >> lsb) & ((32'h0000_0001 << width) - 32'h0000_0001);
    gap_of = f[GAP_W-1:0] + 8'h01;
  endfunction : gap_of

  function automatic logic [2:0] wr_field(input logic [31:0] w);
    wr_field = w[WR_LSB +: WR_W];
  endfunction : wr_field

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic                 sr_bit_q;
  logic                 sr_bit_d;
  logic                 keep_bit_q;
  logic                 keep_bit_d;
  logic [RATE_W-1:0]    rate_q;
  logic [RATE_W-1:0]    rate_d;
  logic [31:0]          tim1_q;
  logic [31:0]          tim1_d;
  logic [1:0]           cfg_q;
  logic [1:0]           cfg_d;
  logic [31:0]          rdata_q;
  logic [31:0]          rdata_d;
  logic                 init_q;
  logic                 init_d;
  logic [RATE_W-1:0]    rfc_twice;
  srtc_sr_state_e       state_q;
  srtc_sr_state_e       state_d;
  logic                 ref_pend_q;
  logic                 ref_pend_d;

  always_comb begin
    sr_bit_d   = sr_bit_q;
    keep_bit_d = keep_bit_q;
    rate_d     = rate_q;
    tim1_d     = tim1_q;
    cfg_d      = cfg_q;
    init_d     = 1'b0;
    rdata_d    = 32'h0000_0000;
    rfc_twice  = {8'h00, tim1_q[RFC_LSB +: RFC_W], 1'b0};
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        OFS_REFRESH_CONTROL: begin
          sr_bit_d   = reg_wdata_in[SELF_REFRESH_BIT];
          keep_bit_d = reg_wdata_in[RSVD_KEEP_BIT];
          if (reg_wdata_in[RATE_LSB +: RATE_W] < RATE_MIN) begin
            rate_d = rfc_twice;
          end else begin
            rate_d = reg_wdata_in[RATE_LSB +: RATE_W];
          end
        end
        OFS_SDRAM_TIMING_ONE: begin
          if (cfg_q[UNLOCK_BIT]) begin
            tim1_d = reg_wdata_in & TIM1_WMASK;
            // only a real change of the field restarts the memory
            init_d = cfg_q[ENABLE_BIT] &&
                     (wr_field(reg_wdata_in) != wr_field(tim1_q));
          end
        end
        OFS_SDRAM_CONFIG: begin
          cfg_d[UNLOCK_BIT] = reg_wdata_in[UNLOCK_BIT];
          cfg_d[ENABLE_BIT] = reg_wdata_in[ENABLE_BIT];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFS_REFRESH_CONTROL: begin
          rdata_d[SELF_REFRESH_BIT]        = sr_bit_q;
          rdata_d[RSVD_KEEP_BIT]           = keep_bit_q;
          rdata_d[RATE_LSB +: RATE_W]      = rate_q;
        end
        OFS_SDRAM_TIMING_ONE: begin
          rdata_d = tim1_q & TIM1_WMASK;
        end
        OFS_SDRAM_CONFIG: begin
          rdata_d[UNLOCK_BIT] = cfg_q[UNLOCK_BIT];
          rdata_d[ENABLE_BIT] = cfg_q[ENABLE_BIT];
        end
        OFS_STATUS: begin
          rdata_d[STAT_STATE_LSB +: 2] = state_q;
          rdata_d[STAT_REFREQ_BIT]     = ref_pend_q;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sr_bit_q   <= 1'b0;
      keep_bit_q <= RSVD_KEEP_RST;
      rate_q     <= RATE_RST;
      tim1_q     <= TIM1_RST;
      cfg_q      <= CFG_RST;
      rdata_q    <= 32'h0000_0000;
      init_q     <= 1'b0;
    end else begin
      sr_bit_q   <= sr_bit_d;
      keep_bit_q <= keep_bit_d;
      rate_q     <= rate_d;
      tim1_q     <= tim1_d;
      cfg_q      <= cfg_d;
      rdata_q    <= rdata_d;
      init_q     <= init_d;
    end
  end

  // ----------------------------------------------------------------
  // self-refresh sequencing and refresh interval
  // ----------------------------------------------------------------
  logic [RATE_W-1:0]    ivl_q;
  logic [RATE_W-1:0]    ivl_d;
  logic                 expire;
  logic                 srq_q;
  logic                 srq_d;
  logic                 insr_q;
  logic                 insr_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SR_RUN:   if (sr_bit_q) begin
        state_d = SR_ENTER;
      end
      SR_ENTER: if (sr_entered_in) begin
        state_d = SR_HOLD;
      end
      SR_HOLD:  if (!sr_bit_q) begin
        state_d = SR_EXIT;
      end
      SR_EXIT:  if (sr_exited_in) begin
        state_d = SR_RUN;
      end
    endcase
    // period equals the rate: reload at one, not at zero
    expire = (ivl_q <= 16'h0001);
    ivl_d  = expire ? rate_q : ivl_q - 16'h0001;
    // a refresh due in the issue cycle is kept: set wins
    if (state_q != SR_RUN) begin
      ref_pend_d = 1'b0;
    end else if (expire) begin
      ref_pend_d = 1'b1;
    end else if (ref_issue_in) begin
      ref_pend_d = 1'b0;
    end else begin
      ref_pend_d = ref_pend_q;
    end
    srq_d  = (state_d == SR_ENTER) || (state_d == SR_HOLD);
    insr_d = (state_d != SR_RUN);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q    <= SR_RUN;
      ivl_q      <= RATE_RST;
      ref_pend_q <= 1'b0;
      srq_q      <= 1'b0;
      insr_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      ivl_q      <= ivl_d;
      ref_pend_q <= ref_pend_d;
      srq_q      <= srq_d;
      insr_q     <= insr_d;
    end
  end

  // ----------------------------------------------------------------
  // command spacing counters
  // ----------------------------------------------------------------
  logic                 rfc_ok;
  logic                 rp_ok;
  logic                 rcd_ok;
  logic                 wr_ok;
  logic                 rc_ok;
  logic                 rrd_ok;
  logic                 wtr_ok;
  logic [BANKS-1:0]     ras_ok;

  srtc_gap_counter u_rfc (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .load_in(ref_issue_in | lmr_issue_in),
    .load_val_in(gap_of(tim1_q, RFC_LSB, RFC_W)), .idle_next_out(rfc_ok));
  srtc_gap_counter u_rp (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .load_in(pre_issue_in),
    .load_val_in(gap_of(tim1_q, RP_LSB, RP_W)), .idle_next_out(rp_ok));
  srtc_gap_counter u_rcd (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .load_in(act_issue_in),
    .load_val_in(gap_of(tim1_q, RCD_LSB, RCD_W)), .idle_next_out(rcd_ok));
  srtc_gap_counter u_wr (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .load_in(wr_last_in),
    .load_val_in(gap_of(tim1_q, WR_LSB, WR_W)), .idle_next_out(wr_ok));
  srtc_gap_counter u_rc (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .load_in(act_issue_in),
    .load_val_in(gap_of(tim1_q, RC_LSB, RC_W)), .idle_next_out(rc_ok));
  srtc_gap_counter u_rrd (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .load_in(act_issue_in),
    .load_val_in(gap_of(tim1_q, RRD_LSB, RRD_W)), .idle_next_out(rrd_ok));
  srtc_gap_counter u_wtr (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .load_in(wr_last_in),
    .load_val_in(gap_of(tim1_q, WTR_LSB, WTR_W)), .idle_next_out(wtr_ok));

  // one activate-to-precharge counter per bank
  for (genvar b = 0; b < BANKS; b++) begin : g_ras
    srtc_gap_counter u_ras (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .load_in(act_issue_in && (act_bank_in == BANK_W'(b))),
      .load_val_in(gap_of(tim1_q, RAS_LSB, RAS_W)), .idle_next_out(ras_ok[b]));
  end

  // ----------------------------------------------------------------
  // permissions, registered so an issue drops them on the next cycle
  // ----------------------------------------------------------------
  logic [BANK_W-1:0]    last_bank_q;
  logic [BANK_W-1:0]    last_bank_d;
  logic [BANKS-1:0]     act_ok_q;
  logic [BANKS-1:0]     act_ok_d;
  logic [BANKS-1:0]     pre_ok_q;
  logic [BANKS-1:0]     pre_ok_d;
  logic                 rd_ok_q;
  logic                 rd_ok_d;
  logic                 wr_ok_q;
  logic                 wr_ok_d;
  logic                 ref_ok_q;
  logic                 ref_ok_d;
  logic                 run_d;

  always_comb begin
    run_d       = (state_d == SR_RUN);
    last_bank_d = act_issue_in ? act_bank_in : last_bank_q;
    for (int b = 0; b < BANKS; b++) begin
      // same bank is covered by the activate cycle gap alone
      act_ok_d[b] = run_d && rfc_ok && rp_ok && rc_ok &&
                    (rrd_ok || (last_bank_d == BANK_W'(b)));
      pre_ok_d[b] = run_d && wr_ok && ras_ok[b];
    end
    rd_ok_d  = run_d && rcd_ok && wtr_ok;
    wr_ok_d  = run_d && rcd_ok;
    ref_ok_d = run_d && rfc_ok && rp_ok;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      last_bank_q <= '0;
      act_ok_q    <= '0;
      pre_ok_q    <= '0;
      rd_ok_q     <= 1'b0;
      wr_ok_q     <= 1'b0;
      ref_ok_q    <= 1'b0;
    end else begin
      last_bank_q <= last_bank_d;
      act_ok_q    <= act_ok_d;
      pre_ok_q    <= pre_ok_d;
      rd_ok_q     <= rd_ok_d;
      wr_ok_q     <= wr_ok_d;
      ref_ok_q    <= ref_ok_d;
    end
  end

  assign reg_rdata_out        = rdata_q;
  assign allow_act_out        = act_ok_q;
  assign allow_pre_out        = pre_ok_q;
  assign allow_rd_out         = rd_ok_q;
  assign allow_wr_out         = wr_ok_q;
  assign allow_ref_out        = ref_ok_q;
  assign refresh_req_out      = ref_pend_q;
  assign self_refresh_req_out = srq_q;
  assign in_self_refresh_out  = insr_q;
  assign init_start_out       = init_q;

endmodule : srtc_refresh_timing

// >>> src/srtc_pkg.sv
// package: register map, field layout, reset values and states of the refresh/timing block
package srtc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int              ADDR_W                  = 8;
  localparam logic [7:0]      OFS_REFRESH_CONTROL     = 8'h00;
  localparam logic [7:0]      OFS_SDRAM_TIMING_ONE    = 8'h04;
  localparam logic [7:0]      OFS_SDRAM_CONFIG        = 8'h08;
  localparam logic [7:0]      OFS_STATUS              = 8'h0C;

  // ----------------------------------------------------------------
  // refresh_control layout
  // ----------------------------------------------------------------
  localparam int              SELF_REFRESH_BIT        = 31;
  localparam int              RSVD_KEEP_BIT           = 30;
  localparam int              RATE_LSB                = 0;
  localparam int              RATE_W                  = 16;
  localparam logic [15:0]     RATE_MIN                = 16'h0100;
  localparam logic [15:0]     RATE_RST                = 16'h0100;
  localparam logic            RSVD_KEEP_RST           = 1'b0;

  // ----------------------------------------------------------------
  // sdram_timing_one layout
  // ----------------------------------------------------------------
  localparam int              RFC_LSB                 = 25;
  localparam int              RFC_W                   = 7;
  localparam int              RP_LSB                  = 22;
  localparam int              RP_W                    = 3;
  localparam int              RCD_LSB                 = 19;
  localparam int              RCD_W                   = 3;
  localparam int              WR_LSB                  = 16;
  localparam int              WR_W                    = 3;
  localparam int              RAS_LSB                 = 11;
  localparam int              RAS_W                   = 5;
  localparam int              RC_LSB                  = 6;
  localparam int              RC_W                    = 5;
  localparam int              RRD_LSB                 = 3;
  localparam int              RRD_W                   = 3;
  localparam int              WTR_LSB                 = 0;
  localparam int              WTR_W                   = 2;
  localparam logic [31:0]     TIM1_RST                = 32'h7FFF_FFFB;
  localparam logic [31:0]     TIM1_WMASK              = 32'hFFFF_FFFB;

  // ----------------------------------------------------------------
  // configuration and status layout
  // ----------------------------------------------------------------
  localparam int              UNLOCK_BIT              = 0;
  localparam int              ENABLE_BIT              = 1;
  localparam logic [1:0]      CFG_RST                 = 2'h0;
  localparam int              STAT_STATE_LSB          = 0;
  localparam int              STAT_REFREQ_BIT         = 2;

  // ----------------------------------------------------------------
  // gap counters and banks
  // ----------------------------------------------------------------
  localparam int              GAP_W                   = 8;
  localparam int              BANKS                   = 8;
  localparam int              BANK_W                  = 3;

  typedef enum logic [1:0] {
    SR_RUN   = 2'b00,
    SR_ENTER = 2'b01,
    SR_HOLD  = 2'b10,
    SR_EXIT  = 2'b11
  } srtc_sr_state_e;

endpackage : srtc_pkg

// >>> src/srtc_gap_counter.sv
// minimum-gap down-counter used for every command spacing
`timescale 1ns/100ps
module srtc_gap_counter (
  input  wire logic                      sys_clk_in,    // system clock
  input  wire logic                      rst_in,        // synchronous reset, active high
  input  wire logic                      load_in,       // governing command issued
  input  wire logic [srtc_pkg::GAP_W-1:0] load_val_in,  // field value plus one
  output logic                           idle_next_out  // counter is zero after this edge
);
  import srtc_pkg::*;

  logic [GAP_W-1:0] cnt_q;
  logic [GAP_W-1:0] cnt_d;

  // ----------------------------------------------------------------
  // count
  // ----------------------------------------------------------------
  always_comb begin
    if (load_in) begin
      cnt_d = load_val_in;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 8'h01;
    end else begin
      cnt_d = cnt_q;
    end
    idle_next_out = (cnt_d == '0);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : srtc_gap_counter

// >>> verif/srtc_sdram_model.sv
// memory-side model: acknowledges self-refresh entry and exit after a delay
`timescale 1ns/100ps
module srtc_sdram_model #(
  parameter int DLY = 5  // cycles before the memory answers
) (
  input  wire logic sys_clk_in,   // system clock
  input  wire logic rst_in,       // synchronous reset
  input  wire logic sr_req_in,    // controller asks for self-refresh
  output logic      entered_out,  // pulse: memory now in self-refresh
  output logic      exited_out    // pulse: memory left self-refresh
);
  logic in_sr_q, in_sr_d;
  int   cnt_q, cnt_d;
  // the memory only follows the request after DLY cycles, never at once
  always_comb begin
    in_sr_d = in_sr_q;
    cnt_d   = 0;
    if (sr_req_in != in_sr_q) begin
      cnt_d = cnt_q + 1;
      if (cnt_q == DLY) begin
        in_sr_d = sr_req_in;
        cnt_d   = 0;
      end
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      in_sr_q     <= 1'b0;
      cnt_q       <= 0;
      entered_out <= 1'b0;
      exited_out  <= 1'b0;
    end else begin
      in_sr_q     <= in_sr_d;
      cnt_q       <= cnt_d;
      entered_out <= in_sr_d & ~in_sr_q;
      exited_out  <= in_sr_q & ~in_sr_d;
    end
  end
endmodule : srtc_sdram_model

// >>> verif/srtc_refresh_timing_sva.sv
// checker: command spacing, read data and self-refresh relations at the ports
`timescale 1ns/100ps
module srtc_refresh_timing_sva (
  input wire logic        sys_clk_in,            // clock
  input wire logic        rst_in,                // reset
  input wire logic        reg_wr_in,             // write strobe
  input wire logic        reg_rd_in,             // read strobe
  input wire logic [31:0] reg_rdata_out,         // read data
  input wire logic        act_issue_in,          // activate
  input wire logic        pre_issue_in,          // precharge
  input wire logic        ref_issue_in,          // refresh
  input wire logic        lmr_issue_in,          // load-mode
  input wire logic        wr_last_in,            // last write data
  input wire logic [7:0]  allow_act_out,         // activate allowed
  input wire logic [7:0]  allow_pre_out,         // precharge allowed
  input wire logic        allow_rd_out,          // read allowed
  input wire logic        allow_wr_out,          // write allowed
  input wire logic        allow_ref_out,         // refresh allowed
  input wire logic        refresh_req_out,       // refresh due
  input wire logic        self_refresh_req_out,  // self-refresh request
  input wire logic        in_self_refresh_out,   // in self-refresh
  input wire logic        init_start_out         // init pulse
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
  act_block_a: assert property (act_issue_in |=> allow_act_out == 8'h00)
    else $error("activate allowed right after activate");
  rcd_block_a: assert property (act_issue_in |=> (!allow_rd_out && !allow_wr_out) [*2])
    else $error("access allowed too early after activate");
  ras_block_a: assert property (act_issue_in |=> allow_pre_out != 8'hFF)
    else $error("precharge allowed to just activated bank");
  pre_block_a: assert property (pre_issue_in |=> allow_act_out == 8'h00 && !allow_ref_out)
    else $error("activate or refresh allowed after precharge");
  rfc_block_a: assert property ((ref_issue_in || lmr_issue_in) |=> !allow_ref_out [*2])
    else $error("refresh allowed too early after refresh");
  wr_rec_a: assert property (wr_last_in |=> allow_pre_out == 8'h00 && !allow_rd_out)
    else $error("precharge or read allowed after write data");
  sr_quiet_a: assert property (in_self_refresh_out && $past(in_self_refresh_out)
    |-> !refresh_req_out && allow_act_out == 8'h00) else $error("activity during self-refresh");
  sr_req_a: assert property (self_refresh_req_out |-> in_self_refresh_out)
    else $error("self-refresh request outside self-refresh state");
  init_pulse_a: assert property (init_start_out |-> $past(reg_wr_in) ##1 !init_start_out)
    else $error("init pulse without write or longer than one cycle");
  cover property (act_issue_in ##[3:20] allow_rd_out);
  cover property (self_refresh_req_out ##[1:60] !in_self_refresh_out);
  cover property (init_start_out);
endmodule : srtc_refresh_timing_sva
bind srtc_refresh_timing srtc_refresh_timing_sva u_sva (.*);

// >>> verif/srtc_refresh_timing_tb_top.sv
// testbench: registers, refresh interval, command spacing and self-refresh
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module srtc_refresh_timing_tb_top;
  import srtc_pkg::*;
  // rfc 5, rp 2, rcd 3, wr 1, ras 6, rc 1, rrd 5, wtr 1; ras kept >= rcd
  localparam logic [31:0] TIM = 32'h0A99_3069;
  logic        sys_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic        act_issue_in = 1'b0, pre_issue_in = 1'b0, ref_issue_in = 1'b0;
  logic        lmr_issue_in = 1'b0, wr_last_in = 1'b0, ini;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out;
  logic [2:0]  act_bank_in = 3'h0;
  logic [7:0]  allow_act_out, allow_pre_out;
  logic        allow_rd_out, allow_wr_out, allow_ref_out, refresh_req_out;
  logic        self_refresh_req_out, in_self_refresh_out, init_start_out;
  logic        sr_entered_in, sr_exited_in;
  int          n_fail = 0, checks = 0, cyc = 0, n;
  time         t0;
  always #50 sys_clk_in = ~sys_clk_in;
  srtc_refresh_timing DUT (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .act_issue_in, .act_bank_in, .pre_issue_in, .ref_issue_in,
    .lmr_issue_in, .wr_last_in, .sr_entered_in, .sr_exited_in, .allow_act_out,
    .allow_pre_out, .allow_rd_out, .allow_wr_out, .allow_ref_out, .refresh_req_out,
    .self_refresh_req_out, .in_self_refresh_out, .init_start_out);
  srtc_sdram_model #(.DLY(5)) u_mem (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .sr_req_in(self_refresh_req_out), .entered_out(sr_entered_in), .exited_out(sr_exited_in));
  // --------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    #1 ini = init_start_out;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 `CHK(reg_rdata_out, e)
  endtask : rd
  function automatic logic sel(input int w);
    case (w)
      0: sel = allow_act_out[0];
      1: sel = allow_act_out[1];
      2: sel = allow_pre_out[0];
      3: sel = allow_rd_out;
      4: sel = allow_ref_out;
      default: sel = allow_wr_out;
    endcase
  endfunction : sel
  // c: 0 act, 1 pre, 2 ref, 3 load-mode, 4 last write; e = field + 1 edges after the issue edge
  task automatic gap(input int c, input int w, input int e);
    @(posedge sys_clk_in);
    {act_issue_in, pre_issue_in, ref_issue_in, lmr_issue_in, wr_last_in} <= 5'h10 >> c;
    @(posedge sys_clk_in);
    {act_issue_in, pre_issue_in, ref_issue_in, lmr_issue_in, wr_last_in} <= 5'h00;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1 n++;
    end while (sel(w) !== 1'b1 && n < 60);
    `CHK(n, e)
    repeat (20) @(posedge sys_clk_in);
  endtask : gap
  task automatic wait_req;
    n = 0;
    #1;
    while (refresh_req_out !== 1'b1 && n < 600) begin
      @(posedge sys_clk_in);
      #1 n++;
    end
    if (n == 600) begin
      n_fail++;
    end
    // acknowledge at once, so the next call waits for a fresh expiry
    @(posedge sys_clk_in);
    ref_issue_in <= 1'b1;
    @(posedge sys_clk_in);
    ref_issue_in <= 1'b0;
  endtask : wait_req
  task automatic conclude;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(8'h00, 32'h0000_0100);
    rd(8'h04, 32'h7FFF_FFFB);
    rd(8'h10, 32'h0000_0000);
    wr(8'h04, TIM);
    rd(8'h04, 32'h7FFF_FFFB);
    wr(8'h08, 32'h0000_0001);
    wr(8'h04, TIM | 32'h0000_0004);
    `CHK(ini, 1'b0)
    rd(8'h04, TIM);
    wr(8'h08, 32'h0000_0003);
    wr(8'h04, TIM + 32'h0001_0000);
    `CHK(ini, 1'b1)
    wr(8'h04, TIM + 32'h0001_0000);
    `CHK(ini, 1'b0)
    wr(8'h04, TIM);
    `CHK(ini, 1'b1)
    wr(8'h00, 32'h3FFF_0040);
    rd(8'h00, 32'h0000_000A);
    wr(8'h00, 32'h0000_0100);
    rd(8'h00, 32'h0000_0100);
    $display("end of test: registers");
    gap(0, 3, 4);
    gap(0, 5, 4);
    gap(0, 0, 2);
    gap(0, 1, 6);
    gap(0, 2, 7);
    gap(1, 0, 3);
    gap(1, 4, 3);
    gap(2, 4, 6);
    gap(3, 0, 6);
    gap(4, 2, 2);
    gap(4, 3, 2);
    $display("end of test: command spacing");
    wait_req;
    wait_req;
    t0 = $time;
    gap(2, 4, 6);
    wait_req;
    `CHK(($time - t0) / 100, 64'd256)
    $display("end of test: refresh interval");
    wr(8'h00, 32'h8000_0100);
    repeat (30) @(posedge sys_clk_in);
    rd(8'h0C, 32'h0000_0002);
    rd(8'h00, 32'h8000_0100);
    n = 0;
    repeat (300) begin
      @(posedge sys_clk_in);
      #1 n += (refresh_req_out !== 1'b0);
    end
    `CHK(n, 0)
    wr(8'h00, 32'h0000_0100);
    repeat (30) @(posedge sys_clk_in);
    #1 `CHK({self_refresh_req_out, in_self_refresh_out}, 2'b00)
    $display("end of test: self-refresh");
    conclude();
  end
endmodule : srtc_refresh_timing_tb_top
